// ---- ahr_pkg.sv ----
// Shared constants and types for the converter readout link and its host controller.
package ahr_pkg;

  // ==========================================================================
  // Clocks and timing
  // ==========================================================================
  localparam int CLK_MHZ  = 100;
  localparam int LINK_NS  = 30;
  localparam int CONV_NS  = 1200;
  localparam int CONV_CYC = (CONV_NS + LINK_NS - 1) / LINK_NS;
  localparam logic [5:0] CONV_LAST = 6'(CONV_CYC - 1);
  localparam int PULSE_NS  = 160;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] PULSE_LAST = 5'(PULSE_CYC - 1);
  localparam int RD_NS  = 240;
  localparam int RD_CYC = (RD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] RD_LAST = 5'(RD_CYC - 1);

  // ==========================================================================
  // Data formats
  // ==========================================================================
  localparam int RES_W = 12;
  localparam int SER_W = 16;
  localparam logic [4:0] SER_LAST = 5'h0f;
  localparam logic [3:0] LEAD_ZEROS = 4'h0;

  // ==========================================================================
  // Synchroniser layouts and reset values
  // ==========================================================================
  localparam int DS_CONV = 5;
  localparam int DS_CS   = 4;
  localparam int DS_RD   = 3;
  localparam int DS_HBE  = 2;
  localparam int DS_WORD = 1;
  localparam int DS_CONT = 0;
  localparam logic [5:0] DEV_SYNC_RST = 6'h3a;
  localparam int HS_BUSY = 3;
  localparam int HS_SCLK = 2;
  localparam int HS_SERIAL_DATA_PIN = 1;
  localparam int HS_STRB = 0;
  localparam logic [3:0] HOST_SYNC_RST = 4'hf;

  // ==========================================================================
  // Host register map
  // ==========================================================================
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CFG    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0c;
  localparam logic [7:0] OFF_SERIAL = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_READ  = 1;
  localparam int CFG_WORD   = 0;
  localparam int CFG_CONT   = 1;
  localparam int CFG_CSSTART = 2;
  localparam logic [2:0] CFG_RST = 3'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    HS_IDLE, HS_PULSE, HS_WAIT_LO, HS_WAIT_HI, HS_RD_LO, HS_GAP, HS_RD_HI
  } ahr_hst_t;

endpackage

// ---- ahr_link_if.sv ----
// Pin-level link between the converter end and its host end.
interface ahr_link_if;
  logic        convert_start_n;
  logic        cs_n;
  logic        rd_n;
  logic        high_byte_select;
  logic        fmt_word;
  logic        fmt_cont;
  logic        busy_int_n;
  logic [11:0] db;
  logic        db_oe;
  logic        sclk_oe;
  logic        serial_data_out_oe;
  logic        strobe_oe;
  logic [11:0] db_bus;
  logic        serial_clk;
  logic        serial_data_pin;
  logic        serial_frame_strobe_n;

  // Open-drain lines are pulled up and only ever pulled low.
  assign db_bus                = db_oe ? db : 12'hfff;
  assign serial_clk            = !sclk_oe;
  assign serial_data_pin       = !serial_data_out_oe;
  assign serial_frame_strobe_n = !strobe_oe;

  modport dev (
    input  convert_start_n, cs_n, rd_n, high_byte_select, fmt_word, fmt_cont,
    output busy_int_n, db, db_oe, sclk_oe, serial_data_out_oe, strobe_oe
  );
  modport host (
    output convert_start_n, cs_n, rd_n, high_byte_select, fmt_word, fmt_cont,
    input  busy_int_n, db_bus, serial_clk, serial_data_pin, serial_frame_strobe_n
  );
endinterface

// ---- ahr_dev.sv ----
// Converter end of the link: conversion control, parallel, byte and serial output.
//
// Notes on behaviour
// - End of conversion drives interrupt line low.
// - Host never captures data during a conversion.
// - Host write produces the start pulse.
// - Host selects byte format, lsb picks byte.
// - One select read starts, stalls, returns.
// - Low byte first; host swaps into place.
// - Only the first byte access stalls.
// - Gated clock: valid data on first fall.
// - Gated clock: serial lines idle when quiet.
// - Host samples falling edges, sixteen bits.
// - Continuous clock: host frames by strobe.
// - Serial follows every conversion in byte format.
// - Serial word: four zeros, result msb first.
// - Byte select picks low or right-justified high.
// - Interrupt idles high, cleared by read.
// - Busy low for the whole conversion.
module ahr_dev (
  input  wire logic        link_clk,
  input  wire logic        rst,
  ahr_link_if.dev          lnk,
  input  wire logic [11:0] sample_value,
  output logic             conv_active,
  output logic             conv_done
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [5:0] sy1_ff;
  logic [5:0] sy2_ff;
  logic [5:0] sy3_ff;
  logic [5:0] nxt_sy1;
  logic [5:0] nxt_sy2;
  logic [5:0] nxt_sy3;

  always_comb begin
    nxt_sy1 = {lnk.convert_start_n, lnk.cs_n, lnk.rd_n,
               lnk.high_byte_select, lnk.fmt_word, lnk.fmt_cont};
    nxt_sy2 = sy1_ff;
    nxt_sy3 = sy2_ff;
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      sy1_ff <= ahr_pkg::DEV_SYNC_RST;
      sy2_ff <= ahr_pkg::DEV_SYNC_RST;
      sy3_ff <= ahr_pkg::DEV_SYNC_RST;
    end else begin
      sy1_ff <= nxt_sy1;
      sy2_ff <= nxt_sy2;
      sy3_ff <= nxt_sy3;
    end
  end

  // ==========================================================================
  // Decoded pin levels and edges
  // ==========================================================================
  logic conv_n;
  logic conv_n_prev;
  logic cs_n;
  logic cs_n_prev;
  logic hbe;
  logic fmt_word;
  logic fmt_cont;
  logic rdsel;
  logic rdsel_prev;
  logic cs_start_mode;
  logic start_ext;
  logic start_cs;
  logic start;
  logic conv_ff;

  assign conv_n      = sy2_ff[ahr_pkg::DS_CONV];
  assign conv_n_prev = sy3_ff[ahr_pkg::DS_CONV];
  assign cs_n        = sy2_ff[ahr_pkg::DS_CS];
  assign cs_n_prev   = sy3_ff[ahr_pkg::DS_CS];
  assign hbe         = sy2_ff[ahr_pkg::DS_HBE];
  assign fmt_word    = sy2_ff[ahr_pkg::DS_WORD];
  assign fmt_cont    = sy2_ff[ahr_pkg::DS_CONT];
  assign rdsel       = !sy2_ff[ahr_pkg::DS_CS] && !sy2_ff[ahr_pkg::DS_RD];
  assign rdsel_prev  = !sy3_ff[ahr_pkg::DS_CS] && !sy3_ff[ahr_pkg::DS_RD];

  // A start line held low means the select line starts conversions.
  assign cs_start_mode = !conv_n && !conv_n_prev;

  assign start_ext = conv_n && !conv_n_prev && cs_n && !conv_ff;

  assign start_cs = cs_start_mode && !cs_n && cs_n_prev && !hbe && !conv_ff;

  assign start = start_ext || start_cs;

  // ==========================================================================
  // Conversion sequencer and status line
  // ==========================================================================
  logic [5:0]  cnt_ff;
  logic [11:0] res_ff;
  logic        int_n_ff;
  logic        done_ff;
  logic        bi_ff;
  logic        nxt_conv;
  logic [5:0]  nxt_cnt;
  logic [11:0] nxt_res;
  logic        nxt_int_n;
  logic        nxt_done;
  logic        nxt_bi;

  always_comb begin
    nxt_conv  = conv_ff;
    nxt_cnt   = cnt_ff;
    nxt_res   = res_ff;
    nxt_int_n = int_n_ff;
    nxt_done  = 1'b0;
    if (rdsel && !rdsel_prev && !conv_ff) begin
      nxt_int_n = 1'b1;
    end
    if (start) begin
      nxt_conv = 1'b1;
      nxt_cnt  = 6'h00;
      nxt_res  = sample_value;
    end else if (conv_ff) begin
      if (cnt_ff == ahr_pkg::CONV_LAST) begin
        nxt_conv = 1'b0;
        nxt_done = 1'b1;
        nxt_int_n = 1'b0;
      end else begin
        nxt_cnt = cnt_ff + 6'h01;
      end
    end
    nxt_bi = cs_start_mode ? !nxt_conv : nxt_int_n;
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      conv_ff  <= 1'b0;
      cnt_ff   <= 6'h00;
      res_ff   <= 12'h000;
      int_n_ff <= 1'b1;
      done_ff  <= 1'b0;
      bi_ff    <= 1'b1;
    end else begin
      conv_ff  <= nxt_conv;
      cnt_ff   <= nxt_cnt;
      res_ff   <= nxt_res;
      int_n_ff <= nxt_int_n;
      done_ff  <= nxt_done;
      bi_ff    <= nxt_bi;
    end
  end

  // ==========================================================================
  // Parallel and byte output
  // ==========================================================================
  logic [11:0] db_ff;
  logic        db_oe_ff;
  logic [11:0] nxt_db;
  logic        nxt_db_oe;

  always_comb begin
    nxt_db_oe = rdsel && !conv_ff && !start;
    if (fmt_word) begin
      nxt_db = res_ff;
    end else if (hbe) begin
      nxt_db = {8'h00, res_ff[11:8]};
    end else begin
      nxt_db = {4'h0, res_ff[7:0]};
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      db_ff    <= 12'h000;
      db_oe_ff <= 1'b0;
    end else begin
      db_ff    <= nxt_db;
      db_oe_ff <= nxt_db_oe;
    end
  end

  // ==========================================================================
  // Serial output
  // ==========================================================================
  logic        pend_ff;
  logic        act_ff;
  logic        sclk_ff;
  logic [15:0] sh_ff;
  logic [4:0]  bits_ff;
  logic        nxt_pend;
  logic        nxt_act;
  logic        nxt_sclk;
  logic [15:0] nxt_sh;
  logic [4:0]  nxt_bits;

  always_comb begin
    nxt_pend = pend_ff || (start && !fmt_word);
    nxt_act  = act_ff;
    nxt_sh   = sh_ff;
    nxt_bits = bits_ff;
    nxt_sclk = (act_ff || fmt_cont) ? !sclk_ff : 1'b0;
    if (pend_ff && !act_ff && !sclk_ff) begin
      nxt_sh   = {ahr_pkg::LEAD_ZEROS, res_ff};
      nxt_pend = 1'b0;
      nxt_act  = 1'b1;
      nxt_bits = 5'h00;
      nxt_sclk = 1'b1;
    end else if (act_ff) begin
      if (sclk_ff) begin
        nxt_bits = bits_ff + 5'h01;
      end else if (bits_ff == ahr_pkg::SER_LAST + 5'h01) begin
        // The frame closes one low phase after the sixteenth fall, so that fall is seen.
        nxt_act  = 1'b0;
        nxt_sclk = fmt_cont;
      end else begin
        nxt_sh = {sh_ff[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      act_ff  <= 1'b0;
      sclk_ff <= 1'b0;
      sh_ff   <= 16'h0000;
      bits_ff <= 5'h00;
    end else begin
      pend_ff <= nxt_pend;
      act_ff  <= nxt_act;
      sclk_ff <= nxt_sclk;
      sh_ff   <= nxt_sh;
      bits_ff <= nxt_bits;
    end
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  assign lnk.busy_int_n         = bi_ff;
  assign lnk.db                 = db_ff;
  assign lnk.db_oe              = db_oe_ff;
  assign lnk.sclk_oe            = (act_ff || fmt_cont) && !sclk_ff;
  assign lnk.serial_data_out_oe = act_ff && !sh_ff[15];
  assign lnk.strobe_oe          = act_ff;
  assign conv_active            = conv_ff;
  assign conv_done              = done_ff;

endmodule // ahr_dev

// ---- ahr_host.sv ----
// Host end of the link: AXI4-Lite registers, read sequencer and serial receiver.
//
// The address map and register access over AXI4-Lite were left to the implementer.
module ahr_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  ahr_link_if.host         lnk,
  output logic [11:0]      serial_word,
  output logic             serial_word_valid
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ahr_pkg::OFF_CTRL) || (a == ahr_pkg::OFF_CFG) ||
             (a == ahr_pkg::OFF_STATUS) || (a == ahr_pkg::OFF_RESULT) ||
             (a == ahr_pkg::OFF_SERIAL);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [3:0] sy1_ff;
  logic [3:0] sy2_ff;
  logic [3:0] sy3_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sy1_ff <= ahr_pkg::HOST_SYNC_RST;
      sy2_ff <= ahr_pkg::HOST_SYNC_RST;
      sy3_ff <= ahr_pkg::HOST_SYNC_RST;
    end else begin
      sy1_ff <= {lnk.busy_int_n, lnk.serial_clk, lnk.serial_data_pin,
                 lnk.serial_frame_strobe_n};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave and registers
  // ==========================================================================
  logic [7:0]  aw_ff, nxt_aw;
  logic        awh_ff, nxt_awh;
  logic [31:0] w_ff, nxt_w;
  logic        ws_ff, nxt_ws;
  logic [15:0] sh_ff, nxt_sh;
  logic        wh_ff, nxt_wh;
  logic        bv_ff, nxt_bv;
  logic [1:0]  br_ff, nxt_br;
  logic        rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic [1:0]  rr_ff, nxt_rr;
  logic [2:0]  cfg_ff, nxt_cfg;
  logic [11:0] res_ff, nxt_res;
  logic        resv_ff, nxt_resv;
  logic [11:0] ser_ff, nxt_ser;
  logic        serv_ff, nxt_serv;
  logic        do_wr, do_rd, cmd_start, cmd_read, res_set, ser_set;
  logic [11:0] res_new;
  ahr_pkg::ahr_hst_t st_ff, nxt_st;

  assign s_axi_awready = !awh_ff && !bv_ff;
  assign s_axi_wready  = !wh_ff && !bv_ff;
  assign s_axi_arready = !rv_ff;
  assign do_wr = awh_ff && wh_ff && !bv_ff;
  assign do_rd = s_axi_arvalid && !rv_ff;
  assign cmd_start = do_wr && aw_ff == ahr_pkg::OFF_CTRL && ws_ff &&
                     w_ff[ahr_pkg::CTRL_START];
  assign cmd_read  = do_wr && aw_ff == ahr_pkg::OFF_CTRL && ws_ff &&
                     w_ff[ahr_pkg::CTRL_READ];

  always_comb begin
    nxt_aw = aw_ff;
    nxt_awh = awh_ff;
    nxt_w = w_ff;
    nxt_wh = wh_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff && !s_axi_bready;
    nxt_br = br_ff;
    nxt_rv = rv_ff && !s_axi_rready;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    nxt_cfg = cfg_ff;
    nxt_res = res_ff;
    nxt_resv = resv_ff;
    nxt_ser = ser_ff;
    nxt_serv = serv_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw = s_axi_awaddr;
      nxt_awh = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w = s_axi_wdata;
      nxt_wh = 1'b1;
      nxt_ws = s_axi_wstrb[0];
    end
    if (do_wr) begin
      nxt_awh = 1'b0;
      nxt_wh = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = mapped(aw_ff) ? ahr_pkg::RESP_OKAY : ahr_pkg::RESP_SLVERR;
      if (aw_ff == ahr_pkg::OFF_CFG && ws_ff) begin
        nxt_cfg = w_ff[2:0];
      end
    end
    if (do_rd) begin
      nxt_rv = 1'b1;
      nxt_rr = mapped(s_axi_araddr) ? ahr_pkg::RESP_OKAY : ahr_pkg::RESP_SLVERR;
      nxt_rd = 32'h0000_0000;
      if (s_axi_araddr == ahr_pkg::OFF_CFG) begin
        nxt_rd = {29'h0, cfg_ff};
      end else if (s_axi_araddr == ahr_pkg::OFF_STATUS) begin
        nxt_rd = {28'h0, sy2_ff[ahr_pkg::HS_BUSY], serv_ff, resv_ff, st_ff != ahr_pkg::HS_IDLE};
      end else if (s_axi_araddr == ahr_pkg::OFF_RESULT) begin
        nxt_rd = {20'h0, res_ff};
        nxt_resv = 1'b0;
      end else if (s_axi_araddr == ahr_pkg::OFF_SERIAL) begin
        nxt_rd = {20'h0, ser_ff};
        nxt_serv = 1'b0;
      end
    end
    if (res_set) begin
      nxt_res = res_new;
      nxt_resv = 1'b1;
    end
    if (ser_set) begin
      nxt_ser = {sh_ff[10:0], sy3_ff[ahr_pkg::HS_SERIAL_DATA_PIN]};
      nxt_serv = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_ff <= 8'h00;
      awh_ff <= 1'b0;
      w_ff <= 32'h0000_0000;
      wh_ff <= 1'b0;
      ws_ff <= 1'b0;
      bv_ff <= 1'b0;
      br_ff <= 2'h0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= 2'h0;
      cfg_ff <= ahr_pkg::CFG_RST;
      res_ff <= 12'h000;
      resv_ff <= 1'b0;
      ser_ff <= 12'h000;
      serv_ff <= 1'b0;
    end else begin
      aw_ff <= nxt_aw;
      awh_ff <= nxt_awh;
      w_ff <= nxt_w;
      wh_ff <= nxt_wh;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
      cfg_ff <= nxt_cfg;
      res_ff <= nxt_res;
      resv_ff <= nxt_resv;
      ser_ff <= nxt_ser;
      serv_ff <= nxt_serv;
    end
  end

  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp  = br_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata  = rd_ff;
  assign s_axi_rresp  = rr_ff;

  // ==========================================================================
  // Conversion and read sequencer
  // ==========================================================================
  logic [4:0] cnt_ff, nxt_cnt;
  logic [7:0] lo_ff, nxt_lo;
  logic       csrd_ff, nxt_csrd;
  logic       hbe_ff, nxt_hbe;
  logic       cvn_ff, nxt_cvn;
  logic       bsy, cs_mode, byte_mode;

  assign bsy = sy2_ff[ahr_pkg::HS_BUSY];
  assign cs_mode = cfg_ff[ahr_pkg::CFG_CSSTART];
  assign byte_mode = !cfg_ff[ahr_pkg::CFG_WORD];

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 5'h01;
    nxt_lo = lo_ff;
    nxt_hbe = hbe_ff;
    res_set = 1'b0;
    res_new = lnk.db_bus;
    case (st_ff)
      ahr_pkg::HS_IDLE: begin
        nxt_cnt = 5'h00;
        nxt_hbe = 1'b0;
        if (cmd_start) begin
          nxt_st = ahr_pkg::HS_PULSE;
        end else if (cmd_read) begin
          nxt_st = ahr_pkg::HS_WAIT_LO;
        end
      end
      ahr_pkg::HS_PULSE: begin
        if (cnt_ff == ahr_pkg::PULSE_LAST) begin
          nxt_st = ahr_pkg::HS_IDLE;
        end
      end
      ahr_pkg::HS_WAIT_LO: begin
        nxt_cnt = 5'h00;
        if (!bsy) begin
          nxt_st = cs_mode ? ahr_pkg::HS_WAIT_HI : ahr_pkg::HS_RD_LO;
        end
      end
      ahr_pkg::HS_WAIT_HI: begin
        nxt_cnt = 5'h00;
        if (bsy) begin
          nxt_st = ahr_pkg::HS_RD_LO;
        end
      end
      ahr_pkg::HS_RD_LO: begin
        if (cnt_ff == ahr_pkg::RD_LAST) begin
          nxt_cnt = 5'h00;
          nxt_lo = lnk.db_bus[7:0];
          // Byte select settles while select is released, not as it falls again.
          nxt_hbe = byte_mode;
          nxt_st = byte_mode ? ahr_pkg::HS_GAP : ahr_pkg::HS_IDLE;
          res_set = !byte_mode;
        end
      end
      ahr_pkg::HS_GAP: begin
        if (cnt_ff == ahr_pkg::RD_LAST) begin
          nxt_cnt = 5'h00;
          nxt_st = ahr_pkg::HS_RD_HI;
        end
      end
      ahr_pkg::HS_RD_HI: begin
        if (cnt_ff == ahr_pkg::RD_LAST) begin
          res_new = {lnk.db_bus[3:0], lo_ff};
          res_set = 1'b1;
          nxt_st = ahr_pkg::HS_IDLE;
        end
      end
      default: begin
        nxt_st = ahr_pkg::HS_IDLE;
      end
    endcase
    nxt_csrd = (nxt_st == ahr_pkg::HS_RD_LO) || (nxt_st == ahr_pkg::HS_RD_HI) ||
               (cs_mode && (nxt_st == ahr_pkg::HS_WAIT_LO || nxt_st == ahr_pkg::HS_WAIT_HI));
    nxt_cvn = !(cs_mode || nxt_st == ahr_pkg::HS_PULSE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= ahr_pkg::HS_IDLE;
      cnt_ff <= 5'h00;
      lo_ff <= 8'h00;
      csrd_ff <= 1'b0;
      hbe_ff <= 1'b0;
      cvn_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      lo_ff <= nxt_lo;
      csrd_ff <= nxt_csrd;
      hbe_ff <= nxt_hbe;
      cvn_ff <= nxt_cvn;
    end
  end

  assign lnk.convert_start_n  = cvn_ff;
  assign lnk.cs_n             = !csrd_ff;
  assign lnk.rd_n             = !csrd_ff;
  assign lnk.high_byte_select = hbe_ff;
  assign lnk.fmt_word         = cfg_ff[ahr_pkg::CFG_WORD];
  assign lnk.fmt_cont         = cfg_ff[ahr_pkg::CFG_CONT];

  // ==========================================================================
  // Serial receiver
  // ==========================================================================
  logic [4:0]  sc_ff, nxt_sc;
  logic        sv_ff;
  logic        fall;

  assign fall = sy3_ff[ahr_pkg::HS_SCLK] && !sy2_ff[ahr_pkg::HS_SCLK] &&
                (!cfg_ff[ahr_pkg::CFG_CONT] || !sy3_ff[ahr_pkg::HS_STRB]);
  assign ser_set = fall && sc_ff == ahr_pkg::SER_LAST;

  always_comb begin
    nxt_sh = sh_ff;
    nxt_sc = sc_ff;
    if (cmd_start) begin
      nxt_sc = 5'h00;
    end else if (fall) begin
      nxt_sh = {sh_ff[14:0], sy3_ff[ahr_pkg::HS_SERIAL_DATA_PIN]};
      nxt_sc = ser_set ? 5'h00 : sc_ff + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_ff <= 16'h0000;
      sc_ff <= 5'h00;
      sv_ff <= 1'b0;
    end else begin
      sh_ff <= nxt_sh;
      sc_ff <= nxt_sc;
      sv_ff <= ser_set;
    end
  end

  assign serial_word       = ser_ff;
  assign serial_word_valid = sv_ff;

endmodule // ahr_host

// ---- ahr_link_properties.sv ----
// Checker for the converter end of the readout link.
module ahr_link_properties (
  input wire logic        link_clk,
  input wire logic        rst,
  input wire logic        convert_start_n,
  input wire logic        cs_n,
  input wire logic        high_byte_select,
  input wire logic        fmt_cont,
  input wire logic        busy_int_n,
  input wire logic [11:0] db,
  input wire logic        db_oe,
  input wire logic        sclk_oe,
  input wire logic        serial_data_out_oe,
  input wire logic        strobe_oe
);
  default clocking @(posedge link_clk);
  endclocking
  default disable iff (rst);
  property p_eoc; $rose(convert_start_n) && cs_n |-> ##[40:50] !busy_int_n; endproperty
  a_eoc: assert property (p_eoc) else $error("no interrupt");
  property p_clr; $fell(cs_n) && convert_start_n && !busy_int_n |-> ##[1:6] busy_int_n;
  endproperty
  a_clr: assert property (p_clr) else $error("interrupt not cleared");
  property p_busy; $fell(busy_int_n) && !convert_start_n |-> !busy_int_n [*8]; endproperty
  a_busy: assert property (p_busy) else $error("busy too short");
  property p_nostall; $fell(cs_n) && high_byte_select && !convert_start_n |-> busy_int_n [*6];
  endproperty
  a_nostall: assert property (p_nostall) else $error("high byte stalled");
  property p_idle; (!fmt_cont && !strobe_oe) [*4] |-> !sclk_oe && !serial_data_out_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("serial lines not idle");
  property p_lead; $rose(strobe_oe) |-> serial_data_out_oe [*6]; endproperty
  a_lead: assert property (p_lead) else $error("leading zeros wrong");
  property p_frame; $rose(strobe_oe) |-> ##28 strobe_oe ##[1:8] !strobe_oe; endproperty
  a_frame: assert property (p_frame) else $error("frame length wrong");
  property p_hi; $rose(db_oe) && high_byte_select |-> db[11:4] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("high byte not justified");
endmodule // ahr_link_properties

// ---- testbench.sv ----
// Bench joining both ends of the readout link, driven over AXI4-Lite.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, link_clk = 1'h0, rst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] sample_value = 12'h000, serial_word;
  logic        conv_active, conv_done, serial_word_valid;
  int          num_errors = 0, check_count = 0;
  int          done_n = 0, sv_n = 0;
  ahr_link_if lnk ();
  ahr_dev ahr_dev_i (.*, .lnk(lnk.dev));
  ahr_host ahr_host_i (.*, .lnk(lnk.host));
  ahr_link_properties ahr_link_properties_i (.link_clk, .rst,
    .convert_start_n(lnk.convert_start_n), .cs_n(lnk.cs_n), .fmt_cont(lnk.fmt_cont),
    .high_byte_select(lnk.high_byte_select), .busy_int_n(lnk.busy_int_n), .db(lnk.db),
    .db_oe(lnk.db_oe), .sclk_oe(lnk.sclk_oe), .serial_data_out_oe(lnk.serial_data_out_oe),
    .strobe_oe(lnk.strobe_oe));
  initial forever #5 clk = ~clk;
  // Pulse counters for the end-of-conversion and serial word strobes.
  always @(posedge link_clk) done_n <= done_n + conv_done;
  always @(posedge clk) sv_n <= sv_n + serial_word_valid;
  initial begin
    #3;
    forever #15 link_clk = ~link_clk;
  end
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge clk);
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(posedge clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    chk("write resp", {30'h0, ahr_pkg::RESP_OKAY}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // Starts unless select-started, reads back, waits for idle and checks the result, and the serial word when ser is set.
  task automatic run(input logic [2:0] cfg, input logic [11:0] v, input logic ser);
    logic [31:0] d;
    logic [1:0]  r;
    int          nd;
    int          ns;
    nd = done_n;
    ns = sv_n;
    sample_value <= v;
    wr(ahr_pkg::OFF_CFG, {29'h0, cfg});
    if (!cfg[2]) wr(ahr_pkg::OFF_CTRL, 32'h1);
    // The read command is only taken by an idle sequencer.
    d = 32'h1;
    while (d[0] !== 1'h0)
      rd(ahr_pkg::OFF_STATUS, d, r);
    wr(ahr_pkg::OFF_CTRL, 32'h2);
    d = 32'h0;
    while (!(d[1] === 1'h1 && d[0] === 1'h0 && (d[2] === 1'h1 || !ser)))
      rd(ahr_pkg::OFF_STATUS, d, r);
    rd(ahr_pkg::OFF_RESULT, d, r);
    chk("result", {20'h0, v}, d);
    if (ser) begin
      rd(ahr_pkg::OFF_SERIAL, d, r);
      chk("serial reg", {20'h0, v}, d);
      chk("serial word", {20'h0, v}, {20'h0, serial_word});
    end
    chk("conversions", nd + 1, done_n);
    chk("conv active", 32'h0, {31'h0, conv_active});
    chk("word valids", ns + !cfg[0], sv_n);
  endtask
  task automatic s_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(ahr_pkg::OFF_CFG, d, r);
    chk("cfg reset", {29'h0, ahr_pkg::CFG_RST}, d);
    rd(8'h14, d, r);
    chk("unmapped resp", {30'h0, ahr_pkg::RESP_SLVERR}, {30'h0, r});
  endtask
  task automatic s_word;
    run(3'h1, 12'ha5c, 1'h0);
  endtask
  task automatic s_gated;
    run(3'h0, 12'h9c3, 1'h1);
  endtask
  task automatic s_cont;
    run(3'h2, 12'h3b6, 1'h1);
  endtask
  task automatic s_byte_select;
    run(3'h4, 12'hf81, 1'h0);
  endtask
  initial begin
    #100us;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    s_regs;
    s_word;
    s_gated;
    s_cont;
    s_byte_select;
    stop_test;
  end
endmodule // testbench
